// file: design/dcf_queue_top.sv
// Functional notes
// - width code picks depth and word width
// - port selects are active low
// - read select high holds read data
// - enable polarities configurable, write low default
// - writes and reads clocked, same clock allowed
// - unpipelined read data appear at read edge
// - pipelined read adds one output register
// - reset zeroes read data and counters
// - reset drives full low, empty high
// - write data 18 bits, low bits used
// - read data high bits meaningless to consumer
`timescale 1ns/1ps
module dcf_queue_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [dcf_pkg::REG_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic queue_reset_n,
    input wire dcf_pkg::dcf_wr_port_t wr_port,
    output logic write_ready,
    input wire logic read_port_select_n,
    input wire logic read_enable,
    output logic [dcf_pkg::DATA_W-1:0] read_data,
    output dcf_pkg::dcf_flags_t queue_flags
);
    import dcf_pkg::*;

    // register decode
    wire sel_cfg = reg_addr == REG_CFG_ADDR;
    wire sel_status = reg_addr == REG_STATUS_ADDR;
    wire sel_thr = reg_addr == REG_THR_ADDR;
    wire sel_err = reg_addr == REG_ERR_ADDR;
    wire cfg_wr = reg_wr && sel_cfg;
    wire thr_wr = reg_wr && sel_thr;
    wire err_wr = reg_wr && sel_err;

    dcf_cfg_t cfg_r;
    dcf_cfg_t cfg_nxt;
    dcf_cfg_t cfg_wdata;
    dcf_thr_t thr_r;
    dcf_flags_t flags_r;
    dcf_flags_t flags_nxt;
    logic [ERR_W-1:0] err_r;
    logic [ERR_W-1:0] err_nxt;
    logic [ERR_W-1:0] err_set;
    logic [31:0] reg_rdata_r;
    logic [31:0] rd_mux;

    assign cfg_wdata = dcf_cfg_t'(reg_wdata[CFG_W-1:0]);

    // reserved codes never reach the port logic
    wire wcode_ok = cfg_wdata.write_width_code <= WCODE_X18;
    wire rcode_ok = cfg_wdata.read_width_code <= WCODE_X18;

    always_comb begin
        cfg_nxt = cfg_r;
        if (cfg_wr) begin
            cfg_nxt.read_pipeline_select = cfg_wdata.read_pipeline_select;
            cfg_nxt.rd_en_high = cfg_wdata.rd_en_high;
            cfg_nxt.wr_en_high = cfg_wdata.wr_en_high;
            if (wcode_ok) begin
                cfg_nxt.write_width_code = cfg_wdata.write_width_code;
            end
            if (rcode_ok) begin
                cfg_nxt.read_width_code = cfg_wdata.read_width_code;
            end
        end
    end

    // queue clear: system reset or the fabric reset pin
    wire clr = rst || !queue_reset_n;

    // port qualification
    wire wr_en_act = ~(wr_port.write_enable ^ cfg_r.wr_en_high);
    wire rd_en_act = ~(read_enable ^ cfg_r.rd_en_high);
    wire wr_go = !wr_port.write_port_select_n && wr_en_act;
    wire rd_try = !read_port_select_n && rd_en_act;

    // geometry of the current configuration
    wire [CNT_W-1:0] depth_w = dcf_depth(cfg_r.write_width_code);
    wire [PTR_W-1:0] last_w = PTR_W'(depth_w - 13'h0001);
    wire [DATA_W-1:0] wmask = dcf_data_mask(cfg_r.write_width_code);
    wire [DATA_W-1:0] rmask = dcf_data_mask(cfg_r.read_width_code);

    // write staging buffer
    logic st_in_ready;
    logic st_valid;
    logic [DATA_W-1:0] st_data;
    wire [DATA_W-1:0] st_in_data = wr_port.write_data_bus & wmask;

    // storage and counters
    logic [DATA_W-1:0] mem_r [MEM_DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;

    wire full_int = count_r == depth_w;
    wire empty_int = count_r == '0;
    wire mem_push = st_valid && !full_int;
    wire rd_go = rd_try && !empty_int;

    assign count_nxt = count_r + CNT_W'(mem_push) - CNT_W'(rd_go);

    wire [PTR_W-1:0] wr_ptr_nxt = (wr_ptr_r == last_w) ? '0 : PTR_W'(wr_ptr_r + 12'h001);
    wire [PTR_W-1:0] rd_ptr_nxt = (rd_ptr_r == last_w) ? '0 : PTR_W'(rd_ptr_r + 12'h001);

    dcf_stage_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(STAGE_DEPTH)
    ) u_stage (
        .core_clk(core_clk),
        .rst(clr),
        .in_valid(wr_go),
        .in_data(st_in_data),
        .in_ready(st_in_ready),
        .out_valid(st_valid),
        .out_data(st_data),
        .out_ready(!full_int)
    );

    always_ff @(posedge core_clk) begin
        if (mem_push) begin
            mem_r[wr_ptr_r] <= st_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clr) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= mem_push ? wr_ptr_nxt : wr_ptr_r;
            rd_ptr_r <= rd_go ? rd_ptr_nxt : rd_ptr_r;
            count_r <= count_nxt;
        end
    end

    // read output path; bits above the read width are forced low
    wire [DATA_W-1:0] rd_word = mem_r[rd_ptr_r] & rmask;
    logic [DATA_W-1:0] read_data_r;
    logic [DATA_W-1:0] pipe_data_r;
    logic pipe_vld_r;

    wire pipe_mode = cfg_r.read_pipeline_select;
    wire load_direct = rd_go && !pipe_mode;
    wire load_pipe = pipe_vld_r && !read_port_select_n;

    // pipelined word waits while the port is deselected
    wire pipe_vld_nxt = (rd_go && pipe_mode) || (pipe_vld_r && read_port_select_n);

    always_ff @(posedge core_clk) begin
        if (clr) begin
            read_data_r <= '0;
            pipe_data_r <= '0;
            pipe_vld_r <= 1'b0;
        end else begin
            pipe_vld_r <= pipe_vld_nxt;
            if (rd_go && pipe_mode) begin
                pipe_data_r <= rd_word;
            end
            if (load_direct) begin
                read_data_r <= rd_word;
            end else if (load_pipe) begin
                read_data_r <= pipe_data_r;
            end
        end
    end

    // flags from the next occupancy
    wire [15:0] cnt_ext = 16'(count_nxt);
    wire [15:0] dep_ext = 16'(depth_w);
    wire af_hit = (thr_r.af_level >= dep_ext) || (cnt_ext >= dep_ext - thr_r.af_level);

    always_comb begin
        flags_nxt.empty_flag = cnt_ext == 16'h0000;
        flags_nxt.almost_empty_flag = cnt_ext <= thr_r.ae_level;
        flags_nxt.full_flag = cnt_ext == dep_ext;
        flags_nxt.almost_full_flag = af_hit;
    end

    always_ff @(posedge core_clk) begin
        if (clr) begin
            flags_r <= FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // sticky error bits, set wins over write-one clear
    always_comb begin
        err_set = '0;
        err_set[ERR_WR_DROP_POS] = wr_go && !st_in_ready;
        err_set[ERR_RD_EMPTY_POS] = rd_try && empty_int;
        err_set[ERR_BAD_CODE_POS] = cfg_wr && !(wcode_ok && rcode_ok);
        err_nxt = err_r & ~(err_wr ? reg_wdata[ERR_W-1:0] : '0);
        err_nxt = err_nxt | err_set;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_r <= CFG_RST;
            thr_r <= THR_RST;
            err_r <= ERR_RST;
        end else begin
            cfg_r <= cfg_nxt;
            thr_r <= thr_wr ? dcf_thr_t'(reg_wdata) : thr_r;
            err_r <= err_nxt;
        end
    end

    // read-back mux, unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_cfg) begin
            rd_mux = 32'(cfg_r);
        end else if (sel_status) begin
            rd_mux = 32'(flags_r);
            rd_mux[ST_COUNT_POS +: CNT_W] = count_r;
        end else if (sel_thr) begin
            rd_mux = thr_r;
        end else if (sel_err) begin
            rd_mux = 32'(err_r);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata_r <= '0;
        end else begin
            reg_rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign write_ready = st_in_ready;
    assign read_data = read_data_r;
    assign queue_flags = flags_r;

endmodule : dcf_queue_top

// file: design/dcf_pkg.sv
package dcf_pkg;

    localparam int DATA_W = 18;
    localparam int PTR_W = 12;
    localparam int CNT_W = 13;
    localparam int MEM_DEPTH = 4096;
    localparam int STAGE_DEPTH = 4;
    localparam int REG_AW = 4;
    localparam int CFG_W = 9;

    // register byte addresses
    localparam logic [REG_AW-1:0] REG_CFG_ADDR = 4'h0;
    localparam logic [REG_AW-1:0] REG_STATUS_ADDR = 4'h4;
    localparam logic [REG_AW-1:0] REG_THR_ADDR = 4'h8;
    localparam logic [REG_AW-1:0] REG_ERR_ADDR = 4'hc;

    // width codes
    localparam logic [2:0] WCODE_X1 = 3'h0;
    localparam logic [2:0] WCODE_X2 = 3'h1;
    localparam logic [2:0] WCODE_X4 = 3'h2;
    localparam logic [2:0] WCODE_X9 = 3'h3;
    localparam logic [2:0] WCODE_X18 = 3'h4;

    // status and error field positions
    localparam int ST_COUNT_POS = 16;
    localparam int ERR_WR_DROP_POS = 0;
    localparam int ERR_RD_EMPTY_POS = 1;
    localparam int ERR_BAD_CODE_POS = 2;
    localparam int ERR_W = 3;

    typedef struct packed {
        logic read_pipeline_select;
        logic rd_en_high;
        logic wr_en_high;
        logic [2:0] read_width_code;
        logic [2:0] write_width_code;
    } dcf_cfg_t;

    typedef struct packed {
        logic [15:0] af_level;
        logic [15:0] ae_level;
    } dcf_thr_t;

    typedef struct packed {
        logic full_flag;
        logic almost_full_flag;
        logic almost_empty_flag;
        logic empty_flag;
    } dcf_flags_t;

    typedef struct packed {
        logic write_port_select_n;
        logic write_enable;
        logic [DATA_W-1:0] write_data_bus;
    } dcf_wr_port_t;

    // reset values
    localparam dcf_cfg_t CFG_RST = 9'h0a4;
    localparam dcf_thr_t THR_RST = 32'h0004_0004;
    localparam dcf_flags_t FLAGS_RST = 4'h3;
    localparam logic [ERR_W-1:0] ERR_RST = 3'h0;

    function automatic logic [DATA_W-1:0] dcf_data_mask(input logic [2:0] code);
        logic [DATA_W-1:0] m;
        m = 18'h00000;
        unique case (code)
            WCODE_X1: m = 18'h00001;
            WCODE_X2: m = 18'h00003;
            WCODE_X4: m = 18'h0000f;
            WCODE_X9: m = 18'h001ff;
            WCODE_X18: m = 18'h3ffff;
            default: m = 18'h3ffff;
        endcase
        return m;
    endfunction : dcf_data_mask

    function automatic logic [CNT_W-1:0] dcf_depth(input logic [2:0] code);
        return 13'h1000 >> code;
    endfunction : dcf_depth

endpackage : dcf_pkg

// file: design/dcf_stage_fifo.sv
`timescale 1ns/1ps
module dcf_stage_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    // depth must be a power of two so the pointers wrap on their own
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic in_ready_r;
    logic out_valid_r;

    wire push = in_valid && in_ready_r;
    wire pop = out_valid_r && out_ready;

    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data = mem_r[rp_r];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready_r <= 1'b0;
            out_valid_r <= 1'b0;
        end else begin
            wp_r <= AW'(wp_r + AW'(push));
            rp_r <= AW'(rp_r + AW'(pop));
            cnt_r <= cnt_nxt;
            in_ready_r <= cnt_nxt != (AW+1)'(DEPTH);
            out_valid_r <= cnt_nxt != '0;
        end
    end

endmodule : dcf_stage_fifo

// file: test/dcf_chk.sv
`timescale 1ns/1ps
module dcf_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic queue_reset_n,
    input wire dcf_pkg::dcf_wr_port_t wr_port,
    input wire logic write_ready,
    input wire logic read_port_select_n,
    input wire logic [dcf_pkg::DATA_W-1:0] read_data,
    input wire dcf_pkg::dcf_flags_t queue_flags
);
    import dcf_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence wr_take;
        !wr_port.write_port_select_n && !wr_port.write_enable && write_ready && queue_reset_n;
    endsequence
    sequence quiet3;
        (!(!wr_port.write_port_select_n && !wr_port.write_enable) && queue_reset_n) [*3];
    endsequence
    rst_flags_a: assert property (!queue_reset_n |=> queue_flags == FLAGS_RST)
        else $error("flags not at reset values");
    rst_data_a: assert property (!queue_reset_n |=> read_data == '0 && !write_ready)
        else $error("read data or ready not cleared");
    sel_hold_a: assert property (read_port_select_n && queue_reset_n |=> $stable(read_data))
        else $error("read data moved while deselected");
    full_af_a: assert property (queue_flags.full_flag |-> queue_flags.almost_full_flag)
        else $error("full without almost full");
    empty_ae_a: assert property (queue_flags.empty_flag |-> queue_flags.almost_empty_flag)
        else $error("empty without almost empty");
    full_empty_a: assert property (!(queue_flags.full_flag && queue_flags.empty_flag))
        else $error("full and empty together");
    wr_fill_a: assert property ((queue_flags.empty_flag ##0 wr_take) ##1 queue_reset_n [*2]
        |-> ##[0:1] !queue_flags.empty_flag) else $error("stored word left queue empty");
    stay_empty_a: assert property (quiet3 ##0 queue_flags.empty_flag |=>
        queue_flags.empty_flag) else $error("empty queue left empty state");
endmodule : dcf_chk

bind dcf_queue_top dcf_chk u_chk (.core_clk, .rst, .queue_reset_n, .wr_port, .write_ready,
    .read_port_select_n, .read_data, .queue_flags);

// file: test/dcf_fab_model.sv
`timescale 1ns/1ps
module dcf_fab_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic send,
    input wire logic [dcf_pkg::DATA_W-1:0] word,
    input wire logic [2:0] code,
    input wire logic write_ready,
    output dcf_pkg::dcf_wr_port_t wr_port,
    output logic busy
);
    import dcf_pkg::*;
    localparam int WB[5] = '{1, 2, 4, 9, 18};
    logic [DATA_W-1:0] mask_w;
    assign mask_w = (18'h1 << WB[code]) - 18'h1;
    assign busy = !wr_port.write_port_select_n;
    // hold the word until ready is seen, then release with toggling data
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_port <= '{1'b1, 1'b1, '0};
        end else if (send) begin
            wr_port <= '{1'b0, 1'b0, word & mask_w};
        end else if (write_ready || !busy) begin
            wr_port <= '{1'b1, 1'b1, ~wr_port.write_data_bus & mask_w};
        end
    end
endmodule : dcf_fab_model

// file: test/dcf_queue_top_tb.sv
`timescale 1ns/1ps
module dcf_queue_top_tb;
    import dcf_pkg::*;
    typedef struct {int due; int kind; logic [31:0] v;} dcf_note_t;
    logic core_clk = 0, rst = 1, queue_reset_n = 0, reg_wr = 0, reg_rd = 0;
    logic read_port_select_n = 1, read_enable = 0, send = 0, busy, write_ready;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    logic [DATA_W-1:0] word = '0, read_data;
    logic [2:0] code = 3'h4;
    dcf_wr_port_t wr_port;
    dcf_flags_t queue_flags;
    dcf_note_t notes[$];
    dcf_note_t n;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    always #20 core_clk = ~core_clk;
    dcf_queue_top dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .queue_reset_n, .wr_port, .write_ready, .read_port_select_n, .read_enable,
        .read_data, .queue_flags);
    dcf_fab_model fab (.core_clk, .rst(rst || !queue_reset_n), .send, .word, .code,
        .write_ready, .wr_port, .busy);
    function automatic logic [DATA_W-1:0] wmask(input logic [2:0] c);
        int b[5] = '{1, 2, 4, 9, 18};
        return (18'h1 << b[c]) - 18'h1;
    endfunction : wmask
    task automatic final_report;
        error_cnt += notes.size();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    task automatic tally(input bit ok, input string what);
        samples_checked++;
        if (!ok) begin
            error_cnt++;
            $display("[FAIL] %0t %s mismatch", $time, what);
        end
    endtask : tally
    task automatic cmp_data(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        tally(g === e, "read data");
    endtask : cmp_data
    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
        tally(g === e, "register");
    endtask : cmp_reg
    task automatic cmp_flags(input logic [3:0] g, input logic [3:0] e);
        tally(g === e, "flags");
    endtask : cmp_flags
    task automatic cmp_ready(input logic g, input logic e);
        tally(g === e, "write ready");
    endtask : cmp_ready
    task automatic note(input int k, input int lat, input logic [31:0] v);
        notes.push_back('{cyc + lat, k, v});
    endtask : note
    always @(negedge core_clk) begin
        cyc++;
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            n = notes.pop_front();
            case (n.kind)
                0: cmp_data(read_data, n.v[DATA_W-1:0]);
                1: cmp_reg(reg_rdata, n.v);
                3: cmp_ready(write_ready, n.v[0]);
                default: cmp_flags(queue_flags, n.v[3:0]);
            endcase
        end
        if (cyc > 3000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic reg_w(input logic [REG_AW-1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_w
    task automatic reg_r(input logic [REG_AW-1:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        note(1, 2, e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask : reg_r
    task automatic wr(input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        word <= d;
        send <= 1'b1;
        @(posedge core_clk);
        send <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 40 && busy; i++) @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic s, input logic [DATA_W-1:0] e, input int lat);
        @(posedge core_clk);
        read_port_select_n <= s;
        read_enable <= 1'b1;
        note(0, 2 + lat, e);
        @(posedge core_clk);
        read_enable <= 1'b0;
        repeat (lat) @(posedge core_clk);
        read_port_select_n <= 1'b1;
    endtask : rd
    initial begin
        logic [DATA_W-1:0] d, d2;
        void'($urandom(32'h639e7cad));
        repeat (16) @(posedge core_clk);
        note(2, 1, FLAGS_RST);
        note(0, 1, 0);
        rst <= 1'b0;
        queue_reset_n <= 1'b1;
        reg_r(REG_CFG_ADDR, CFG_RST);
        reg_r(REG_THR_ADDR, THR_RST);
        reg_r(4'h2, 32'h0);
        for (int c = 0; c < 5; c++) begin
            code <= c[2:0];
            reg_w(REG_CFG_ADDR, {23'h0, 3'h2, c[2:0], c[2:0]});
            d = DATA_W'($urandom);
            wr(d);
            repeat (3) @(posedge core_clk);
            rd(1'b0, d & wmask(c[2:0]), 0);
        end
        rd(1'b1, d, 0);
        rd(1'b0, d, 0);
        reg_r(REG_ERR_ADDR, 32'h2);
        reg_w(REG_ERR_ADDR, 32'h7);
        reg_r(REG_ERR_ADDR, 32'h0);
        // reserved width codes keep the old codes, other fields still taken
        reg_w(REG_CFG_ADDR, 32'h1ad);
        reg_r(REG_CFG_ADDR, 32'h1a4);
        reg_r(REG_ERR_ADDR, 32'h4);
        d = DATA_W'($urandom);
        wr(d);
        repeat (3) @(posedge core_clk);
        rd(1'b0, d, 1);
        // read enable made active low: a high enable must not read
        reg_w(REG_CFG_ADDR, 32'h124);
        d2 = DATA_W'($urandom);
        wr(d2);
        rd(1'b0, d, 0);
        reg_w(REG_CFG_ADDR, 32'h1a4);
        rd(1'b0, d2, 1);
        // fill storage, then the four staging words
        for (int i = 0; i < 260; i++) wr(DATA_W'($urandom));
        repeat (4) @(posedge core_clk);
        note(2, 1, 4'hc);
        note(3, 1, 0);
        reg_r(REG_STATUS_ADDR, 32'h0100_000c);
        queue_reset_n <= 1'b0;
        @(posedge core_clk);
        queue_reset_n <= 1'b1;
        note(2, 1, FLAGS_RST);
        note(0, 1, 0);
        note(3, 1, 0);
        repeat (4) @(posedge core_clk);
        note(3, 1, 1);
        repeat (2) @(posedge core_clk);
        final_report();
    end
endmodule : dcf_queue_top_tb
